// File: design/level_flag.sv
/*
  One level flag: set by hardware while its fill condition holds, cleared
  only by a write of zero that follows a read which returned it as one.
  Assumes read_one and write_zero are single-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps
module level_flag (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // condition and software access
  input wire logic cond,
  input wire logic read_one,
  input wire logic write_zero,
  // state
  output logic flag,
  output logic set_pulse
);

  logic flag_q, flag_d;
  logic armed_q, armed_d;

  // ----------------------------------------------------------------
  // next state: a set in the clearing cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    flag_d = flag_q;
    armed_d = armed_q;
    if (read_one && flag_q) begin
      armed_d = 1'b1;
    end
    if (write_zero && armed_q) begin
      flag_d = 1'b0;
      armed_d = 1'b0;
    end
    if (cond) begin
      flag_d = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      armed_q <= armed_d;
    end
  end

  assign flag = flag_q;
  assign set_pulse = cond & ~flag_q;  // rising of the flag, next edge

endmodule // level_flag

// File: design/serial_fifo_level_irq.sv
/*
  FIFO level flags, interrupt requests and DMA requests of a FIFO-buffered
  serial port, with an AXI4-Lite register slave.
  Assumes the FIFO fill counts come from logic on ref_clk and that the
  DMA controller and processor sit on the same clock.
*/
// Function
// - tx interrupt request is high while tx_level_flag is one.
// - set tx_level_flag may also start the DMA controller filling tx FIFO.
// - rx interrupt request is high while rx_level_flag is one.
// - set rx_level_flag may start the DMA controller draining rx FIFO.
// - tx fill at or below tx trigger sets tx_level_flag again after clear.
// - rx fill at or above rx trigger sets rx_level_flag again after clear.
`timescale 1ns/1ps
module serial_fifo_level_irq
  import serial_fifo_level_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // fifo fill levels
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  // requests
  output logic tx_level_interrupt,
  output logic rx_level_interrupt,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wr_state_t wr_q, wr_d;
  rd_state_t rd_q, rd_d;
  logic aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  ctrl_t ctrl_q, ctrl_d;
  logic [CNT_W-1:0] tx_trig_q, tx_trig_d, rx_trig_q, rx_trig_d;
  logic [1:0] event_q, event_d, mask_q, mask_d;
  logic [1:0] cond, flag, set_pulse, read_one, write_zero;
  logic do_write, do_read;
  logic [31:0] bit_en;

  // ----------------------------------------------------------------
  // level flags, one per direction
  // ----------------------------------------------------------------
  assign cond[TX_BIT] = (tx_fifo_count <= tx_trig_q);
  assign cond[RX_BIT] = (rx_fifo_count >= rx_trig_q);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_flag
      // read pulse arms only when the returned bit is one
      assign read_one[g] = do_read && (s_axi_araddr == STATUS_OFFS);
      assign write_zero[g] = do_write && (awaddr_q == STATUS_OFFS)
                             && wstrb_q[0] && !wdata_q[g];
      level_flag u_flag (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .cond(cond[g]),
        .read_one(read_one[g]),
        .write_zero(write_zero[g]),
        .flag(flag[g]),
        .set_pulse(set_pulse[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // request outputs, straight from flag, event and enable flops
  // ----------------------------------------------------------------
  assign tx_level_interrupt = flag[TX_BIT] & ctrl_q.tx_int_en;
  assign rx_level_interrupt = flag[RX_BIT] & ctrl_q.rx_int_en;
  assign tx_dma_req = flag[TX_BIT] & ctrl_q.tx_dma_en;
  assign rx_dma_req = flag[RX_BIT] & ctrl_q.rx_dma_en;
  assign irq = |(event_q & mask_q);

  // ----------------------------------------------------------------
  // axi write path: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = (wr_q == WR_RESP);
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_held_q && w_held_q && (wr_q == WR_IDLE);
  assign bit_en = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  always_comb begin
    wr_d = wr_q;
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    tx_trig_d = tx_trig_q;
    rx_trig_d = rx_trig_q;
    mask_d = mask_q;
    event_d = event_q;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    case (wr_q)
      WR_IDLE: begin
        if (do_write) begin
          aw_held_d = 1'b0;
          w_held_d = 1'b0;
          wr_d = WR_RESP;
          bresp_d = RESP_OKAY;
          case (awaddr_q)
            STATUS_OFFS: ;  // flag clears handled in level_flag
            CTRL_OFFS: begin
              if (wstrb_q[0]) begin
                ctrl_d = ctrl_t'(wdata_q[3:0]);
              end
            end
            TRIG_OFFS: begin
              tx_trig_d = (tx_trig_q & ~bit_en[TRIG_TX_LSB +: CNT_W])
                          | (wdata_q[TRIG_TX_LSB +: CNT_W] & bit_en[TRIG_TX_LSB +: CNT_W]);
              rx_trig_d = (rx_trig_q & ~bit_en[TRIG_RX_LSB +: CNT_W])
                          | (wdata_q[TRIG_RX_LSB +: CNT_W] & bit_en[TRIG_RX_LSB +: CNT_W]);
            end
            LEVEL_OFFS: ;  // read only, write ignored
            EVENT_OFFS: begin
              if (wstrb_q[0]) begin
                event_d = event_q & ~wdata_q[1:0];
              end
            end
            MASK_OFFS: begin
              if (wstrb_q[0]) begin
                mask_d = wdata_q[1:0];
              end
            end
            default: bresp_d = RESP_SLVERR;
          endcase
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_d = WR_IDLE;
        end
      end
      default: wr_d = WR_IDLE;
    endcase
    // a new flag edge in the clearing cycle survives
    event_d = event_d | set_pulse;
  end

  // ----------------------------------------------------------------
  // axi read path: one cycle from address to data
  // ----------------------------------------------------------------
  assign s_axi_arready = (rd_q == RD_IDLE);
  assign s_axi_rvalid = (rd_q == RD_DATA);
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign do_read = s_axi_arvalid && (rd_q == RD_IDLE);

  always_comb begin
    rd_d = rd_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rd_q)
      RD_IDLE: begin
        if (do_read) begin
          rd_d = RD_DATA;
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_OKAY;
          case (s_axi_araddr)
            STATUS_OFFS: rdata_d[1:0] = flag;
            CTRL_OFFS: rdata_d[3:0] = ctrl_q;
            TRIG_OFFS: begin
              rdata_d[TRIG_TX_LSB +: CNT_W] = tx_trig_q;
              rdata_d[TRIG_RX_LSB +: CNT_W] = rx_trig_q;
            end
            LEVEL_OFFS: begin
              rdata_d[TRIG_TX_LSB +: CNT_W] = tx_fifo_count;
              rdata_d[TRIG_RX_LSB +: CNT_W] = rx_fifo_count;
            end
            EVENT_OFFS: rdata_d[1:0] = event_q;
            MASK_OFFS: rdata_d[1:0] = mask_q;
            default: rresp_d = RESP_SLVERR;
          endcase
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          rd_d = RD_IDLE;
        end
      end
      default: rd_d = RD_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers only
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_q <= WR_IDLE;
      rd_q <= RD_IDLE;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      ctrl_q <= ctrl_t'(CTRL_RST);
      tx_trig_q <= CNT_W'(TX_TRIG_RST);
      rx_trig_q <= CNT_W'(RX_TRIG_RST);
      event_q <= 2'h0;
      mask_q <= MASK_RST;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      tx_trig_q <= tx_trig_d;
      rx_trig_q <= rx_trig_d;
      event_q <= event_d;
      mask_q <= mask_d;
    end
  end

endmodule // serial_fifo_level_irq

// File: design/serial_fifo_level_pkg.sv
/*
  Shared constants and types for the FIFO level flag and interrupt block
  of a FIFO-buffered serial port: register map, field positions, reset
  values and the bus state encodings.
  Assumes a 32-bit AXI4-Lite register bus and an 8-bit byte address.
*/
package serial_fifo_level_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFFS = 8'h00;  // serial_status_register
  localparam logic [7:0] CTRL_OFFS = 8'h04;    // enables
  localparam logic [7:0] TRIG_OFFS = 8'h08;    // trigger amounts
  localparam logic [7:0] LEVEL_OFFS = 8'h0C;   // fifo fill levels, read only
  localparam logic [7:0] EVENT_OFFS = 8'h10;   // sticky events, write one to clear
  localparam logic [7:0] MASK_OFFS = 8'h14;    // event mask

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int TX_BIT = 0;        // tx_level_flag position in status, event, mask
  localparam int RX_BIT = 1;        // rx_level_flag position
  localparam int TRIG_TX_LSB = 0;   // tx trigger in byte 0 of trigger/level regs
  localparam int TRIG_RX_LSB = 8;   // rx trigger in byte 1
  localparam int TX_TRIG_RST = 8;
  localparam int RX_TRIG_RST = 1;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_dma_en;
    logic tx_dma_en;
    logic rx_int_en;
    logic tx_int_en;
  } ctrl_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

endpackage

// File: verif/fifo_partner.sv
/* dma and fifo model on the far side of the level flags.
   assumes the bench pulses tx_drain and rx_fill and sets stall. */
`timescale 1ns/1ps
module fifo_partner #(
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // requests and controls
  input wire logic tx_dma_req,
  input wire logic rx_dma_req,
  input wire logic stall,
  input wire logic tx_drain,
  input wire logic rx_fill,
  // fill levels
  output logic [CNT_W-1:0] tx_fifo_count,
  output logic [CNT_W-1:0] rx_fifo_count
);
  logic tx_put, tx_take, rx_put, rx_take;
  // dma fills past the trigger before anyone clears the flag
  assign tx_put = tx_dma_req && !stall && tx_fifo_count < CNT_W'(DEPTH);
  assign tx_take = tx_drain && tx_fifo_count != '0;
  assign rx_put = rx_fill && rx_fifo_count < CNT_W'(DEPTH);
  // dma drains all pending bytes, stall models a slow controller
  assign rx_take = rx_dma_req && !stall && rx_fifo_count != '0;
  always_ff @(posedge ref_clk) begin
    tx_fifo_count <= rst_n ? tx_fifo_count + CNT_W'(tx_put) - CNT_W'(tx_take) : '0;
    rx_fifo_count <= rst_n ? rx_fifo_count + CNT_W'(rx_put) - CNT_W'(rx_take) : '0;
  end
endmodule // fifo_partner

// File: verif/level_irq_checker.sv
/* checker for the level flag requests and bus answer timing.
   assumes default triggers and request enables that never fall. */
`timescale 1ns/1ps
module level_irq_checker
  import serial_fifo_level_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // levels and requests
  input wire logic [CNT_W-1:0] tx_fifo_count,
  input wire logic [CNT_W-1:0] rx_fifo_count,
  input wire logic tx_level_interrupt,
  input wire logic rx_level_interrupt,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic tx_on_q, rx_on_q, tx_ok, rx_ok;
  assign tx_ok = tx_fifo_count <= CNT_W'(TX_TRIG_RST);
  assign rx_ok = rx_fifo_count >= CNT_W'(RX_TRIG_RST);
  // a request seen once means enabled; reset forgets it
  always_ff @(posedge ref_clk) begin
    tx_on_q <= rst_n && (tx_on_q || tx_dma_req);
    rx_on_q <= rst_n && (rx_on_q || rx_dma_req);
  end
  a_tx_pair: assert property (
    $changed(tx_level_interrupt) |-> tx_level_interrupt == tx_dma_req) else $error("tx pair");
  a_rx_pair: assert property (
    $changed(rx_level_interrupt) |-> rx_level_interrupt == rx_dma_req) else $error("rx pair");
  a_tx_keep: assert property (tx_dma_req && tx_ok |=> tx_dma_req)
    else $error("tx flag lost");
  a_rx_keep: assert property (rx_dma_req && rx_ok |=> rx_dma_req)
    else $error("rx flag lost");
  a_tx_back: assert property (tx_on_q && !tx_dma_req && tx_ok |=> tx_dma_req)
    else $error("tx flag not back");
  a_rx_back: assert property (rx_on_q && !rx_dma_req && rx_ok |=> rx_dma_req)
    else $error("rx flag not back");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("late read");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("late write");
  c_tx_clear: cover property ($fell(tx_dma_req));
  c_rx_clear: cover property ($fell(rx_dma_req));
  c_tx_back: cover property (tx_on_q && !tx_dma_req ##1 tx_dma_req);
endmodule // level_irq_checker

bind serial_fifo_level_irq level_irq_checker #(.DEPTH(DEPTH), .CNT_W(CNT_W)) u_chk (
  .ref_clk, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .tx_fifo_count,
  .rx_fifo_count, .tx_level_interrupt, .rx_level_interrupt, .tx_dma_req, .rx_dma_req);

// File: verif/tb.sv
/* bench: bus master, partner and random traffic around the level flags.
   assumes the bound checker and the partner model. */
`timescale 1ns/1ps
module tb;
  import serial_fifo_level_pkg::*;
  localparam int DEPTH = 16;
  localparam int CNT_W = 5;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 0;
  logic s_axi_wvalid = 0;
  logic s_axi_arvalid = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [31:0] s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [CNT_W-1:0] tx_fifo_count, rx_fifo_count;
  logic tx_level_interrupt, rx_level_interrupt, tx_dma_req, rx_dma_req;
  logic stall = 1;
  logic tx_drain = 0;
  logic rx_fill = 0;
  logic [31:0] seed = 32'h1e1c_4120;
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  // responses are always accepted at once
  serial_fifo_level_irq #(.DEPTH(DEPTH), .CNT_W(CNT_W)) u_serial_fifo_level_irq (
    .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .tx_fifo_count, .rx_fifo_count,
    .tx_level_interrupt, .rx_level_interrupt, .tx_dma_req, .rx_dma_req, .irq);
  fifo_partner #(.DEPTH(DEPTH), .CNT_W(CNT_W)) u_fifo_partner (.ref_clk, .rst_n,
    .tx_dma_req, .rx_dma_req, .stall, .tx_drain, .rx_fill, .tx_fifo_count, .rx_fifo_count);
  initial forever #2.5 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // status expected once both flags were cleared with counts frozen
  function automatic logic [31:0] cond(input logic [CNT_W-1:0] t, input logic [CNT_W-1:0] x);
    return {30'h0, x >= CNT_W'(RX_TRIG_RST), t <= CNT_W'(TX_TRIG_RST)};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic pa, pw;
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (pa || pw) begin
      @(posedge ref_clk);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // read as one arms the flag, then zero is written to it only
  task automatic clr(input int b);
    rd(STATUS_OFFS);
    wr(STATUS_OFFS, 32'h3 ^ (32'h1 << b));
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hang guard, the run needs about a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    rd(TRIG_OFFS);
    chk("trig", 32'(TX_TRIG_RST) | (32'(RX_TRIG_RST) << TRIG_RX_LSB), d);
    rd(8'h18);
    chk("bad rresp", {30'h0, RESP_SLVERR}, {d[31:2], r});
    wr(8'h18, 32'hffff_ffff);
    chk("bad bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(EVENT_OFFS);
    chk("event", 32'h1, d);
    wr(MASK_OFFS, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(EVENT_OFFS, 32'h1);
    chk("irq clr", 32'h0, {31'h0, irq});
    wr(CTRL_OFFS, 32'hf);
    chk("tx req", 32'h3, {30'h0, tx_level_interrupt, tx_dma_req});
    clr(TX_BIT);
    chk("tx kept", 32'h1, {31'h0, tx_level_interrupt});
    stall <= 0;
    while (tx_fifo_count != CNT_W'(DEPTH)) @(posedge ref_clk);
    stall <= 1;
    clr(TX_BIT);
    chk("tx clr", 32'h0, {30'h0, tx_level_interrupt, tx_dma_req});
    tx_drain <= 1;
    while (tx_fifo_count > CNT_W'(TX_TRIG_RST)) @(posedge ref_clk);
    tx_drain <= 0;
    repeat (3) @(posedge ref_clk);
    chk("tx back", 32'h3, {30'h0, tx_level_interrupt, irq});
    rx_fill <= 1;
    repeat (3) @(posedge ref_clk);
    rx_fill <= 0;
    repeat (2) @(posedge ref_clk);
    chk("rx req", 32'h3, {30'h0, rx_level_interrupt, rx_dma_req});
    clr(RX_BIT);
    chk("rx kept", 32'h1, {31'h0, rx_level_interrupt});
    stall <= 0;
    while (rx_fifo_count != '0) @(posedge ref_clk);
    stall <= 1;
    clr(RX_BIT);
    chk("rx clr", 32'h0, {30'h0, rx_level_interrupt, rx_dma_req});
    // random traffic with occasional clears; the checker watches it
    repeat (400) begin
      @(posedge ref_clk);
      seed = xs(seed);
      tx_drain <= seed[0];
      rx_fill <= seed[1];
      stall <= seed[2];
      if (seed[7:5] == 3'h0) clr(32'(seed[8]));
    end
    @(posedge ref_clk);
    tx_drain <= 0;
    rx_fill <= 0;
    stall <= 1;
    @(posedge ref_clk);
    clr(TX_BIT);
    clr(RX_BIT);
    rd(STATUS_OFFS);
    chk("status", cond(tx_fifo_count, rx_fifo_count), d);
    // counts are frozen here, so the level register must mirror the partner
    wr(LEVEL_OFFS, 32'hffff_ffff);
    chk("level bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    rd(LEVEL_OFFS);
    chk("level", 32'(tx_fifo_count) | (32'(rx_fifo_count) << TRIG_RX_LSB), d);
    rd(CTRL_OFFS);
    chk("ctrl", 32'hf, d);
    rd(MASK_OFFS);
    chk("mask", 32'h3, d);
    report_and_stop();
  end
endmodule // tb
